/* design/dsc_device.sv */
// Device end of the serial command port: shift register, command decode,
// register file and read-back shifter.
// Assumes link pins are asynchronous to CLK_I and that STATUS_I is on CLK_I.
//
// What this block does
// R1: Shift 24 bits MSB first on rising edges.
// R2: Frame is address byte then data word.
// R3: Host gives 24 clocks before strobe rises.
// R4: Shift always; capture on every strobe rise.
// R5: Reset clears input shift register to zero.
// R6: Codes 01, 55, 57 write code, control, config.
// R7: Codes 58, 59 write gain and zero trims.
// R8: 56 reset, 95 watchdog, 96 checksum clear; 00 idle.
// R9: Code 02 reads; selector in data bits 5:0.
// R10: Host follows a read with a no-op frame.
// R11: Read data out MSB first on falling edges.
// R12: Low selector bits pick status, code, control.
// R13: Full selectors pick config, gain, zero trims.
// R14: Clock may burst; strobe after full count.
// R15: Wrong clock counts misalign data, no error.
// R16: Frame starts at top bit; strobe updates.
// R17: Shared bus needs per-device gated clock.
// R18: Serial clock at most 30 MHz.
// R19: Narrow variant keeps bits 15:4 of code, gain, zero, low zero; control and config keep all 16.
// R20: Unknown address codes change nothing.
`default_nettype none

module dsc_device
   import dsc_pkg::*;
#(
   parameter int DATA_BITS = DSC_DATA_BITS
)(
   // Clock and reset.
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   // Serial link.
   dsc_link_if.device       LINK,
   // Fault and slew status from the output stage.
   input  wire logic [4:0]  STATUS_I,
   // Register contents.
   output logic      [15:0] CODE_O,
   output logic      [15:0] CONTROL_O,
   output logic      [15:0] CONFIG_O,
   output logic      [15:0] GAIN_O,
   output logic      [15:0] ZERO_O,
   // Command pulses.
   output logic             SOFT_RESET_O,
   output logic             WDOG_RESTART_O,
   output logic             CRC_CLEAR_O
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // Only the full and the twelve-bit register widths exist.
   if (DATA_BITS != 16 && DATA_BITS != 12)
   begin : g_bad_width
      $error("dsc_device: DATA_BITS must be 16 or 12");
   end

   // Bits below the register width are dropped on code, gain and zero writes and read as zero; control and config keep all 16 bits.
   localparam logic [15:0] KEEP_MASK = 16'hFFFF << (16 - DATA_BITS); // see R19

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [2:0]  sclk_sync_q;
   logic [2:0]  latch_sync_q;
   logic [1:0]  sdi_sync_q;
   wire         sclk_rise;
   wire         sclk_fall;
   wire         latch_rise;

   // Stage zero feeds stage one only; edges are taken from the later stages.
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         sclk_sync_q  <= 3'h0;
         latch_sync_q <= 3'h0;
         sdi_sync_q   <= 2'h0;
      end
      else
      begin
         sclk_sync_q  <= {sclk_sync_q[1:0], LINK.sclk};
         latch_sync_q <= {latch_sync_q[1:0], LINK.latch};
         sdi_sync_q   <= {sdi_sync_q[0], LINK.sdi};
      end
   end

   // Data and clock go through equal delays, so the sampled bit lines up.
   assign sclk_rise  = sclk_sync_q[1] & ~sclk_sync_q[2]; // see R18
   assign sclk_fall  = ~sclk_sync_q[1] & sclk_sync_q[2];
   assign latch_rise = latch_sync_q[1] & ~latch_sync_q[2];

   // ---------------------------------------------------------------
   // Input shift register
   // ---------------------------------------------------------------
   logic [23:0] in_q;
   logic [23:0] in_d;
   wire  [7:0]  cmd_addr;
   wire  [15:0] cmd_data;
   wire  [15:0] wr_data;
   wire         soft_reset;

   // Shifting ignores the strobe, so a clock meant for another device
   // still moves bits in here; a shared bus must gate the clock.
   assign in_d = sclk_rise ? {in_q[22:0], sdi_sync_q[1]} : in_q; // see R1, R4, R17

   // Reset and the reset command both return the shifter to zero.
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I || soft_reset)
      begin
         in_q <= DSC_SHIFT_RESET; // see R5
      end
      else
      begin
         in_q <= in_d;
      end
   end

   // ---------------------------------------------------------------
   // Command decode at the strobe
   // ---------------------------------------------------------------
   // Whatever sits in the shifter is taken as it is: a miscounted frame
   // simply decodes shifted bits, there is no framing check.
   assign cmd_addr = in_q[DSC_ADDR_MSB:DSC_ADDR_LSB]; // see R2, R15, R16
   assign cmd_data = in_q[DSC_DATA_MSB:0];
   assign wr_data  = cmd_data & KEEP_MASK; // see R19

   wire wr_code    = latch_rise && (cmd_addr == DSC_ADDR_CODE); // see R4, R6
   wire wr_control = latch_rise && (cmd_addr == DSC_ADDR_CONTROL); // see R6
   wire wr_config  = latch_rise && (cmd_addr == DSC_ADDR_CONFIG); // see R6
   wire wr_gain    = latch_rise && (cmd_addr == DSC_ADDR_GAIN); // see R7
   wire wr_zero    = latch_rise && (cmd_addr == DSC_ADDR_ZERO); // see R7
   wire rd_req     = latch_rise && (cmd_addr == DSC_ADDR_READ); // see R9
   wire wdog_cmd   = latch_rise && (cmd_addr == DSC_ADDR_WDOG); // see R8
   wire crc_cmd    = latch_rise && (cmd_addr == DSC_ADDR_CRC_CLEAR); // see R8
   // The reset register acts only when its reset bit is written as one.
   assign soft_reset = latch_rise && (cmd_addr == DSC_ADDR_SOFTRST)
                       && cmd_data[DSC_RESET_BIT]; // see R8

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [15:0] code_q;
   logic [15:0] control_q;
   logic [15:0] config_q;
   logic [15:0] gain_q;
   logic [15:0] zero_q;

   // Address codes outside the table match no strobe, so nothing moves.
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I || soft_reset)
      begin
         code_q    <= DSC_CODE_RESET;
         control_q <= DSC_CONTROL_RESET;
         config_q  <= DSC_CONFIG_RESET;
         gain_q    <= DSC_GAIN_RESET;
         zero_q    <= DSC_ZERO_RESET;
      end
      else
      begin
         code_q    <= wr_code    ? wr_data : code_q; // see R6, R20
         control_q <= wr_control ? cmd_data : control_q; // see R6
         config_q  <= wr_config  ? cmd_data : config_q; // see R6
         gain_q    <= wr_gain    ? wr_data : gain_q; // see R7
         zero_q    <= wr_zero    ? wr_data : zero_q; // see R7
      end
   end

   // Command pulses last one clock each.
   logic soft_reset_q;
   logic wdog_q;
   logic crc_q;

   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         soft_reset_q <= 1'b0;
         wdog_q       <= 1'b0;
         crc_q        <= 1'b0;
      end
      else
      begin
         soft_reset_q <= soft_reset;
         wdog_q       <= wdog_cmd; // see R8
         crc_q        <= crc_cmd; // see R8
      end
   end

   // ---------------------------------------------------------------
   // Read selection
   // ---------------------------------------------------------------
   wire [5:0]  rd_sel    = cmd_data[DSC_SEL_MSB:0]; // see R9
   wire [15:0] status_w  = {11'h000, STATUS_I};
   wire        sel_short = (rd_sel[1:0] != 2'h3);
   wire [15:0] rd_short;
   wire [15:0] rd_long;
   wire [15:0] rd_word;

   // Low two bits alone decide the first three; the upper four are ignored.
   assign rd_short = (rd_sel[1:0] == DSC_SEL_STATUS)  ? status_w  :
                     (rd_sel[1:0] == DSC_SEL_CODE)    ? code_q    :
                     (rd_sel[1:0] == DSC_SEL_CONTROL) ? control_q :
                     16'h0000; // see R12
   // An unlisted long selector returns zero rather than stale data.
   assign rd_long  = (rd_sel == DSC_SEL_CONFIG) ? config_q :
                     (rd_sel == DSC_SEL_GAIN)   ? gain_q   :
                     (rd_sel == DSC_SEL_ZERO)   ? zero_q   :
                     16'h0000; // see R13
   assign rd_word  = sel_short ? rd_short : rd_long;

   // ---------------------------------------------------------------
   // Output shifter
   // ---------------------------------------------------------------
   logic [23:0] out_q;
   logic [23:0] out_d;

   // A read loads the reply for the next frame; any other strobe empties
   // the shifter, and each falling clock edge moves the next bit out.
   assign out_d = rd_req     ? {DSC_READ_PAD, rd_word} : // see R10
                  latch_rise ? DSC_SHIFT_RESET :
                  sclk_fall  ? {out_q[22:0], 1'b0} : // see R11
                  out_q;

   always_ff @(posedge CLK_I)
   begin
      if (SRST_I || soft_reset)
      begin
         out_q <= DSC_SHIFT_RESET;
      end
      else
      begin
         out_q <= out_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Every output is a flip-flop; the link bit is the shifter's top bit.
   assign LINK.sdo       = out_q[23]; // see R11
   assign CODE_O         = code_q;
   assign CONTROL_O      = control_q;
   assign CONFIG_O       = config_q;
   assign GAIN_O         = gain_q;
   assign ZERO_O         = zero_q;
   assign SOFT_RESET_O   = soft_reset_q;
   assign WDOG_RESTART_O = wdog_q;
   assign CRC_CLEAR_O    = crc_q;

   // The serial clock rate limit is met by sampling at CLK_I: each clock
   // phase must last at least three CLK_I periods for the edge detector.

endmodule : dsc_device

`default_nettype wire

/* design/dsc_host.sv */
// Host end of the serial command port: sends one 24-bit frame per command,
// appends a no-op frame after a read, and returns the bits shifted back.
// Assumes the link reply pin is asynchronous to CLK_I.
`default_nettype none

module dsc_host
   import dsc_pkg::*;
#(
   parameter int HALF_CYC = DSC_SCLK_HALF_CYC
)(
   // Clock and reset.
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   // Serial link.
   dsc_link_if.host         LINK,
   // Command request.
   input  wire logic        CMD_VALID_I,
   input  wire logic [7:0]  CMD_ADDR_I,
   input  wire logic [15:0] CMD_DATA_I,
   output logic             CMD_READY_O,
   // Frame result.
   output logic             DONE_O,
   output logic      [23:0] RD_DATA_O
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The device's edge detector needs three clocks per phase.
   if (HALF_CYC < 3 || HALF_CYC > 255)
   begin : g_bad_half
      $error("dsc_host: HALF_CYC must be 3 to 255");
   end

   localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1); // see R18

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_LOW      = 3'h1,
      ST_HIGH     = 3'h3,
      ST_LATCH_HI = 3'h2,
      ST_LATCH_LO = 3'h6
   } dsc_host_state_type;

   // ---------------------------------------------------------------
   // Reply synchroniser and phase timer
   // ---------------------------------------------------------------
   logic [1:0] sdo_sync_q;
   logic [7:0] div_q;
   wire        tick = (div_q == 8'h00);

   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         sdo_sync_q <= 2'h0;
         div_q      <= HALF_LOAD;
      end
      else
      begin
         sdo_sync_q <= {sdo_sync_q[0], LINK.sdo};
         div_q      <= tick ? HALF_LOAD : div_q - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Frame sequencer
   // ---------------------------------------------------------------
   dsc_host_state_type state_q;
   logic [23:0] frame_q;
   logic [23:0] cap_q;
   logic [4:0]  bit_q;
   logic        sclk_q;
   logic        sdi_q;
   logic        latch_q;
   logic        is_read_q;
   logic        nop_q;
   logic        ready_q;
   logic        done_q;
   logic [23:0] rd_q;
   wire         last_bit = (bit_q == 5'(DSC_FRAME_BITS - 1));
   wire         need_nop = is_read_q && !nop_q;

   // The strobe only rises after all 24 clocks; the clock idles low
   // between frames and runs only inside them, but it is one wire and is
   // not gated per device, so every device on the bus sees it.
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         state_q   <= ST_IDLE;
         frame_q   <= DSC_SHIFT_RESET;
         cap_q     <= DSC_SHIFT_RESET;
         bit_q     <= 5'h00;
         sclk_q    <= 1'b0;
         sdi_q     <= 1'b0;
         latch_q   <= 1'b0;
         is_read_q <= 1'b0;
         nop_q     <= 1'b0;
         ready_q   <= 1'b1;
         done_q    <= 1'b0;
         rd_q      <= DSC_SHIFT_RESET;
      end
      else
      begin
         done_q <= 1'b0;
         unique case (state_q)
            ST_IDLE:
            begin
               if (CMD_VALID_I && tick)
               begin
                  frame_q   <= {CMD_ADDR_I, CMD_DATA_I}; // see R2
                  sdi_q     <= CMD_ADDR_I[7];
                  is_read_q <= (CMD_ADDR_I == DSC_ADDR_READ); // see R9
                  bit_q     <= 5'h00;
                  ready_q   <= 1'b0;
                  state_q   <= ST_LOW;
               end
            end
            ST_LOW:
            begin
               if (tick)
               begin
                  sclk_q  <= 1'b1;
                  state_q <= ST_HIGH;
               end
            end
            ST_HIGH:
            begin
               if (tick)
               begin
                  // Sample the reply just before the edge that changes it.
                  sclk_q  <= 1'b0;
                  cap_q   <= {cap_q[22:0], sdo_sync_q[1]};
                  frame_q <= {frame_q[22:0], 1'b0};
                  sdi_q   <= frame_q[22];
                  bit_q   <= bit_q + 5'h01;
                  if (last_bit)
                  begin
                     latch_q <= 1'b1; // see R3, R14
                     state_q <= ST_LATCH_HI;
                  end
                  else
                  begin
                     state_q <= ST_LOW;
                  end
               end
            end
            ST_LATCH_HI:
            begin
               if (tick)
               begin
                  latch_q <= 1'b0;
                  state_q <= ST_LATCH_LO;
               end
            end
            ST_LATCH_LO:
            begin
               if (tick && need_nop)
               begin
                  frame_q <= {DSC_ADDR_NOP, 16'h0000}; // see R10
                  sdi_q   <= 1'b0;
                  nop_q   <= 1'b1;
                  bit_q   <= 5'h00;
                  state_q <= ST_LOW;
               end
               else if (tick)
               begin
                  rd_q    <= cap_q;
                  done_q  <= 1'b1;
                  nop_q   <= 1'b0;
                  ready_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign LINK.sclk   = sclk_q; // see R17
   assign LINK.sdi    = sdi_q;
   assign LINK.latch  = latch_q;
   assign CMD_READY_O = ready_q;
   assign DONE_O      = done_q;
   assign RD_DATA_O   = rd_q;

endmodule : dsc_host

`default_nettype wire

/* design/dsc_link_if.sv */
// Four-wire serial link between the command port and its host.
// Assumes the bench instantiates it and joins both ends to it.
`default_nettype none

interface dsc_link_if;

   // Host driven clock, data and load strobe; device driven read data.
   logic sclk;
   logic sdi;
   logic latch;
   logic sdo;

   modport device (input sclk, input sdi, input latch, output sdo);
   modport host   (output sclk, output sdi, output latch, input sdo);

endinterface : dsc_link_if

`default_nettype wire

/* design/dsc_pkg.sv */
// Shared constants of the serial command port: frame layout, command codes,
// read selectors, reset values and link timing.
// Assumes both ends and the bench compile it first.
`default_nettype none

package dsc_pkg;

   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int DSC_FRAME_BITS = 24;
   localparam int DSC_ADDR_MSB   = 23;
   localparam int DSC_ADDR_LSB   = 16;
   localparam int DSC_DATA_MSB   = 15;
   localparam int DSC_DATA_BITS  = 16;
   localparam int DSC_SEL_MSB    = 5;
   localparam int DSC_RESET_BIT  = 0;

   // ---------------------------------------------------------------
   // Address byte codes
   // ---------------------------------------------------------------
   localparam logic [7:0] DSC_ADDR_NOP       = 8'h00;
   localparam logic [7:0] DSC_ADDR_CODE      = 8'h01;
   localparam logic [7:0] DSC_ADDR_READ      = 8'h02;
   localparam logic [7:0] DSC_ADDR_CONTROL   = 8'h55;
   localparam logic [7:0] DSC_ADDR_SOFTRST   = 8'h56;
   localparam logic [7:0] DSC_ADDR_CONFIG    = 8'h57;
   localparam logic [7:0] DSC_ADDR_GAIN      = 8'h58;
   localparam logic [7:0] DSC_ADDR_ZERO      = 8'h59;
   localparam logic [7:0] DSC_ADDR_WDOG      = 8'h95;
   localparam logic [7:0] DSC_ADDR_CRC_CLEAR = 8'h96;

   // ---------------------------------------------------------------
   // Read selectors
   // ---------------------------------------------------------------
   localparam logic [1:0] DSC_SEL_STATUS  = 2'h0;
   localparam logic [1:0] DSC_SEL_CODE    = 2'h1;
   localparam logic [1:0] DSC_SEL_CONTROL = 2'h2;
   localparam logic [5:0] DSC_SEL_CONFIG  = 6'h0B;
   localparam logic [5:0] DSC_SEL_GAIN    = 6'h13;
   localparam logic [5:0] DSC_SEL_ZERO    = 6'h17;
   localparam logic [7:0] DSC_READ_PAD    = 8'h00;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [23:0] DSC_SHIFT_RESET   = 24'h000000;
   localparam logic [15:0] DSC_CODE_RESET    = 16'h0000;
   localparam logic [15:0] DSC_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] DSC_CONFIG_RESET  = 16'h0000;
   localparam logic [15:0] DSC_GAIN_RESET    = 16'h0000;
   localparam logic [15:0] DSC_ZERO_RESET    = 16'h0000;

   // ---------------------------------------------------------------
   // Link timing
   // ---------------------------------------------------------------
   localparam int DSC_CLK_HZ       = 200_000_000;
   localparam int DSC_SCLK_MAX_HZ  = 30_000_000;
   // Half period rounded up so the generated clock never exceeds the limit.
   localparam int DSC_SCLK_HALF_CYC =
      (DSC_CLK_HZ + 2 * DSC_SCLK_MAX_HZ - 1) / (2 * DSC_SCLK_MAX_HZ);

endpackage : dsc_pkg

`default_nettype wire

/* verification/dsc_link_chk.sv */
// Checker of the four serial link wires between host and device ends.
// Assumes the bench wires it to the link and the host clock, HALF_CYC is 4.
`default_nettype none

module dsc_link_chk
   import dsc_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic SRST_I,
   // Link wires.
   input wire logic sclk,
   input wire logic sdi,
   input wire logic latch,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking dcb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);

   logic        sclk_q;
   logic        latch_q;
   logic        pend_q;
   logic [4:0]  cnt_q;
   logic [23:0] sh_q;
   wire         sclk_rise  = sclk & ~sclk_q;
   wire         sclk_fall  = ~sclk & sclk_q;
   wire         latch_rise = latch & ~latch_q;

   // Frame tracker; pend_q marks the frame that must carry a read reply.
   always_ff @(posedge CLK_I)
   begin
      sclk_q  <= SRST_I ? 1'b0 : sclk;
      latch_q <= SRST_I ? 1'b0 : latch;
      sh_q    <= SRST_I ? 24'h000000 : (sclk_rise ? {sh_q[22:0], sdi} : sh_q);
      cnt_q   <= (SRST_I | latch_rise) ? 5'h00 : cnt_q + {4'h0, sclk_rise};
      pend_q  <= SRST_I ? 1'b0 : (latch_rise ? sh_q[23:16] == DSC_ADDR_READ : pend_q);
   end

   // Phase shapes; the high phase and the strobe must last exactly four cycles, the low phase at least four.
   sequence s_high;
      sclk[*4] ##1 !sclk;
   endsequence
   sequence s_strobe;
      latch[*4] ##1 !latch;
   endsequence

   AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high)
      else $error("Serial clock high phase is not four cycles.");
   AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
      else $error("Serial clock low phase is too short.");
   AST_SDI_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdi))
      else $error("Serial data moved while the clock was high.");
   AST_LATCH_LOW_SCLK: assert property (latch |-> !sclk)
      else $error("Strobe high while the serial clock was high.");
   AST_LATCH_PULSE: assert property ($rose(latch) |-> s_strobe)
      else $error("Strobe pulse is not four cycles long.");
   AST_BIT_COUNT: assert property (latch_rise |-> cnt_q == 5'h18)
      else $error("Strobe rose after a count other than 24.");
   AST_READ_NOP: assert property (latch_rise && pend_q |-> sh_q == 24'h000000)
      else $error("Read request not followed by a no-op frame.");
   AST_SDO_HOLD: assert property ($fell(sclk) |-> $stable(sdo))
      else $error("Reply bit moved at the host sampling edge.");
   AST_REPLY_PAD: assert property (pend_q && sclk_fall && cnt_q <= 5'h08 |-> !sdo)
      else $error("Reply pad byte is not zero.");
   AST_SCLK_GATED: assert property (sclk_rise |-> cnt_q < 5'h18)
      else $error("Serial clock ran past a full frame without a strobe.");

endmodule // dsc_link_chk

`default_nettype wire

/* verification/tb_top.sv */
// Bench: host and device ends joined by the link, driven from the host user side.
// Assumes the package, link interface, both ends and the link checker compile first.
`default_nettype none

module tb_top
   import dsc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        srst;
   logic        cmd_valid;
   logic [7:0]  cmd_addr;
   logic [15:0] cmd_data;
   logic [4:0]  status;
   logic        cmd_ready;
   logic        done;
   logic [23:0] rd_data;
   logic [15:0] code;
   logic [15:0] control;
   logic [15:0] cfg;
   logic [15:0] gain;
   logic [15:0] zero;
   logic        soft_rst;
   logic        wdog;
   logic        crc_clr;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          n_soft = 0;
   int          n_wdog = 0;
   int          n_crc = 0;
   logic [7:0]  wr_addr [5] = '{DSC_ADDR_CODE, DSC_ADDR_CONTROL, DSC_ADDR_CONFIG,
                                DSC_ADDR_GAIN, DSC_ADDR_ZERO};
   logic [5:0]  rd_sel [5] = '{6'h3D, 6'h3E, DSC_SEL_CONFIG, DSC_SEL_GAIN, DSC_SEL_ZERO};
   logic [15:0] wr_val [5] = '{16'hA5C3, 16'h5A3C, 16'h1234, 16'hFEDC, 16'h8001};

   dsc_link_if dsc_link_if_i ();
   dsc_device dsc_device_i (.CLK_I(clk), .SRST_I(srst), .LINK(dsc_link_if_i),
      .STATUS_I(status), .CODE_O(code), .CONTROL_O(control), .CONFIG_O(cfg),
      .GAIN_O(gain), .ZERO_O(zero), .SOFT_RESET_O(soft_rst),
      .WDOG_RESTART_O(wdog), .CRC_CLEAR_O(crc_clr));
   dsc_host dsc_host_i (.CLK_I(clk), .SRST_I(srst), .LINK(dsc_link_if_i),
      .CMD_VALID_I(cmd_valid), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
      .CMD_READY_O(cmd_ready), .DONE_O(done), .RD_DATA_O(rd_data));
   dsc_link_chk dsc_link_chk_i (.CLK_I(clk), .SRST_I(srst), .sclk(dsc_link_if_i.sclk),
      .sdi(dsc_link_if_i.sdi), .latch(dsc_link_if_i.latch), .sdo(dsc_link_if_i.sdo));

   // A twelve-bit device overhears every frame; only its register levels are judged.
   logic [15:0] code12;
   logic [15:0] gain12;
   logic [15:0] zero12;
   dsc_link_if dsc_link12_i ();
   assign dsc_link12_i.sclk  = dsc_link_if_i.sclk;
   assign dsc_link12_i.sdi   = dsc_link_if_i.sdi;
   assign dsc_link12_i.latch = dsc_link_if_i.latch;
   dsc_device #(.DATA_BITS(12)) dsc_device12_i (.CLK_I(clk), .SRST_I(srst),
      .LINK(dsc_link12_i), .STATUS_I(status), .CODE_O(code12), .CONTROL_O(),
      .CONFIG_O(), .GAIN_O(gain12), .ZERO_O(zero12), .SOFT_RESET_O(),
      .WDOG_RESTART_O(), .CRC_CLEAR_O());

   // 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Pulse counters and the hang limit; a whole run needs about 5000 cycles.
   // Pulses are counted on the falling edge, away from the edge that launches them.
   always @(negedge clk)
   begin
      n_soft += (soft_rst === 1'b1);
      n_wdog += (wdog === 1'b1);
      n_crc  += (crc_clr === 1'b1);
      cycles++;
      if (cycles == 30000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One command through the host; valid is held until the host takes it.
   task automatic send(input logic [7:0] a, input logic [15:0] d);
      int w;
      w = 0;
      @(negedge clk);
      cmd_addr  = a;
      cmd_data  = d;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b0 && w < 20)
      begin
         @(negedge clk);
         w++;
      end
      cmd_valid = 1'b0;
      while (done !== 1'b1 && w < 1000)
      begin
         @(negedge clk);
         w++;
      end
      check(24'(w < 1000), 24'h000001);
   endtask

   // Writes every register, then reads each back with junk in unused bits.
   task automatic t_regs();
      for (int i = 0; i < 5; i++)
      begin
         send(wr_addr[i], wr_val[i]);
      end
      check({code, 8'h00}, {wr_val[0], 8'h00});
      check({control, 8'h00}, {wr_val[1], 8'h00});
      check({cfg, 8'h00}, {wr_val[2], 8'h00});
      check({gain, 8'h00}, {wr_val[3], 8'h00});
      check({zero, 8'h00}, {wr_val[4], 8'h00});
      check({code12, gain12[7:0]}, {wr_val[0] & 16'hFFF0, wr_val[3][7:0] & 8'hF0});
      check({zero12, 8'h00}, {wr_val[4] & 16'hFFF0, 8'h00});
      for (int i = 0; i < 5; i++)
      begin
         send(DSC_ADDR_READ, {10'h2AB, rd_sel[i]});
         check(rd_data, {8'h00, wr_val[i]});
      end
      send(DSC_ADDR_READ, {10'h3FF, 6'h3C});
      check(rd_data, {19'h00000, status});
   endtask

   // Command codes, idle and unknown codes, then a soft reset.
   task automatic t_cmds();
      int s;
      int w;
      int c;
      s = n_soft;
      w = n_wdog;
      c = n_crc;
      send(DSC_ADDR_WDOG, 16'hFFFF);
      send(DSC_ADDR_CRC_CLEAR, 16'hFFFF);
      send(DSC_ADDR_NOP, 16'hFFFF);
      send(8'h33, 16'hFFFF);
      check(24'(n_wdog - w), 24'h000001);
      check(24'(n_crc - c), 24'h000001);
      check(24'(n_soft - s), 24'h000000);
      check({gain, code[7:0]}, {wr_val[3], wr_val[0][7:0]});
      send(DSC_ADDR_SOFTRST, 16'h0001);
      check(24'(n_soft - s), 24'h000001);
      check({code, control[7:0]}, 24'h000000);
      send(DSC_ADDR_READ, 16'h0001);
      check(rd_data, 24'h000000);
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      srst      = 1'b1;
      cmd_valid = 1'b0;
      cmd_addr  = 8'h00;
      cmd_data  = 16'h0000;
      status    = 5'h15;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      t_regs();
      t_cmds();
      complete_run();
   end

endmodule // tb_top

`default_nettype wire
